// *** common/sas_defs.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * converter sequencer. Assumes a 32-bit classic Wishbone slave, byte addresses.
 */
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

// ==========================================================================
// register byte offsets
`define SAS_OFF_CTRL        8'h00
`define SAS_OFF_CHSEL       8'h04
`define SAS_OFF_STATUS      8'h08
`define SAS_OFF_BND_HIGH    8'h0C
`define SAS_OFF_BND_LOW     8'h10
`define SAS_OFF_BND_CHAN    8'h14
`define SAS_OFF_RESULT_BASE 8'h40
`define SAS_OFF_RESULT_END  8'hC0

// ==========================================================================
// control register fields
`define SAS_CTRL_EN         0
`define SAS_CTRL_MODE_LSB   1
`define SAS_CTRL_SRC_LSB    4
`define SAS_CTRL_FALLING    6
`define SAS_CTRL_BY4        7
`define SAS_CTRL_IRQ_EN     8
`define SAS_CTRL_BND_EN     9
`define SAS_CTRL_OUTSIDE    10
`define SAS_CTRL_DIV_LSB    11
`define SAS_CTRL_START      14
`define SAS_CTRL_STOP       15

// ==========================================================================
// channel select fields and status bits
`define SAS_CHSEL_FIX_LSB   8
`define SAS_CHSEL_DUALB_LSB 12
`define SAS_STAT_DONE       0
`define SAS_STAT_BND        1
`define SAS_STAT_BUSY       2

// ==========================================================================
// reset values and conversion timing
`define SAS_CTRL_RST        14'h0000
`define SAS_CHSEL_RST       15'h0001
`define SAS_BND_HIGH_RST    10'h3FF
`define SAS_BND_LOW_RST     10'h000
`define SAS_MSB_BIT         4'd9
`define SAS_EARLY_BIT       4'd6
`define SAS_MID_BIT         4'd2
`define SAS_MASK_EARLY      10'h3C0
`define SAS_MASK_MID        10'h3FC
`define SAS_MASK_FULL       10'h3FF

`endif

// *** common/sas_pkg.sv ***
/*
 * Types shared by the converter sequencer.
 * Assumes the mode field encodes the modes in declaration order.
 */
package sas_pkg;
    // ======================================================================
    // operating modes and sequencer states
    typedef enum logic [2:0] {
        SAS_FIX_SINGLE, SAS_FIX_CONT, SAS_SCAN_SINGLE,
        SAS_SCAN_CONT, SAS_DUAL_CONT, SAS_STEP
    } sas_mode_e;

    typedef enum logic [1:0] {SAS_SRC_TIMER, SAS_SRC_IMMED, SAS_SRC_EDGE} sas_src_e;

    typedef enum logic [1:0] {SAS_IDLE, SAS_SAMPLE, SAS_CONVERT} sas_state_e;
endpackage

// *** design/sas_sequencer.sv ***
/*
 * Sequencer for an eight-input 10-bit successive approximation converter:
 * channel selection, start sources, result pairs, boundary compare, divider.
 * Assumes the analog mux, sample-and-hold, DAC and comparator sit outside;
 * cmpHigh is the comparator answer for the current dacCode, valid each tick.
 */
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "sas_defs.svh"

module sas_sequencer
    import sas_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // start sources and power state
    input  wire logic        timerOvf,
    input  wire logic        edgeTriggerPin,
    input  wire logic        powerDown,
    // analog front end
    input  wire logic        cmpHigh,
    output logic      [2:0]  chanSel,
    output logic             sampleEn,
    output logic      [9:0]  dacCode,
    output logic             analogOn,
    // interrupt request, also the wake source out of idle
    output logic             intReq
);
    // ======================================================================
    // functions
    function automatic logic [31:0] applyWr(input logic [31:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (dat & m);
    endfunction

    // next selected channel above cur; bit 3 set when the search wrapped
    function automatic logic [3:0] nextChan(input logic [7:0] mask, input logic [2:0] cur);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (mask[i]) begin
                r = (3'(i) > cur) ? {1'b0, 3'(i)} : ((r[3] | ~|r) ? {1'b1, 3'(i)} : r);
            end
        end
        for (int i = 7; i >= 0; i--) begin
            if (mask[i] && 3'(i) > cur) begin
                r = {1'b0, 3'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic isOutside(input logic [9:0] v, input logic [9:0] hi,
                                       input logic [9:0] lo, input logic [9:0] m);
        return (v > (hi & m)) || (v < (lo & m));
    endfunction

    // ======================================================================
    // registers
    logic [13:0] ctrl_ff;
    logic [14:0] chSel_ff;
    logic [9:0]  bndHi_ff, bndLo_ff;
    logic        doneFlag_ff, bndFlag_ff;
    logic [7:0]  bndChan_ff;
    logic [9:0]  res_ff [8];
    logic        ack_ff;
    logic [31:0] rdData_ff;
    sas_state_e  state_ff, nxtState;
    logic [2:0]  chan_ff, nxtChan, slot_ff, nxtSlot, divCnt_ff;
    logic [3:0]  bitIdx_ff, nxtBit, scanCnt_ff, nxtScanCnt;
    logic [9:0]  code_ff, nxtCode, dac_ff, nxtDac;
    logic        dualB_ff, nxtDualB, pinPrev_ff, sample_ff, analogOn_ff, intReq_ff;
    logic        startPend_ff;

    // ======================================================================
    // control field decode
    wire        enable   = ctrl_ff[`SAS_CTRL_EN];
    wire sas_mode_e mode = sas_mode_e'(ctrl_ff[`SAS_CTRL_MODE_LSB +: 3]);
    wire sas_src_e  src  = sas_src_e'(ctrl_ff[`SAS_CTRL_SRC_LSB +: 2]);
    wire        falling  = ctrl_ff[`SAS_CTRL_FALLING];
    wire        by4      = ctrl_ff[`SAS_CTRL_BY4];
    wire        irqEn    = ctrl_ff[`SAS_CTRL_IRQ_EN];
    wire        bndEn    = ctrl_ff[`SAS_CTRL_BND_EN];
    wire        outside  = ctrl_ff[`SAS_CTRL_OUTSIDE];
    wire [2:0]  divRatio = ctrl_ff[`SAS_CTRL_DIV_LSB +: 3];
    wire [7:0]  scanMask = chSel_ff[7:0];
    wire [2:0]  fixChan  = chSel_ff[`SAS_CHSEL_FIX_LSB +: 3];
    wire [2:0]  dualChan = chSel_ff[`SAS_CHSEL_DUALB_LSB +: 3];

    // ======================================================================
    // bus decode; a write lands on the edge where the master sees ack
    wire        wbReq   = wb_cyc_i & wb_stb_i;
    wire        wbWr    = wbReq & wb_we_i & ack_ff;
    wire        wrCtrl  = wbWr && wb_adr_i == `SAS_OFF_CTRL;
    wire        wrStat  = wbWr && wb_adr_i == `SAS_OFF_STATUS;
    wire        wrChan  = wbWr && wb_adr_i == `SAS_OFF_BND_CHAN;
    wire [31:0] ctrlNew = applyWr({16'h0000, 2'b00, ctrl_ff}, wb_dat_i, wb_sel_i);
    wire        startWr = wrCtrl & ctrlNew[`SAS_CTRL_START];
    wire        abort   = (wrCtrl & ctrlNew[`SAS_CTRL_STOP]) | ~enable;
    wire [7:0]  resOff  = wb_adr_i - `SAS_OFF_RESULT_BASE;
    wire [31:0] statNew = applyWr(32'h0000_0000, wb_dat_i, wb_sel_i);
    wire [31:0] chSelNew = applyWr({17'h0_0000, chSel_ff}, wb_dat_i, wb_sel_i);
    wire [31:0] bndHiNew = applyWr({22'h00_0000, bndHi_ff}, wb_dat_i, wb_sel_i);
    wire [31:0] bndLoNew = applyWr({22'h00_0000, bndLo_ff}, wb_dat_i, wb_sel_i);
    logic [31:0] rdData;

    always_comb begin
        rdData = 32'h0000_0000; // unmapped offsets answer with zero
        if (wb_adr_i == `SAS_OFF_CTRL) begin
            rdData = {18'h0_0000, ctrl_ff};
        end else if (wb_adr_i == `SAS_OFF_CHSEL) begin
            rdData = {17'h0_0000, chSel_ff};
        end else if (wb_adr_i == `SAS_OFF_STATUS) begin
            rdData = {29'h0000_0000, state_ff != SAS_IDLE, bndFlag_ff, doneFlag_ff};
        end else if (wb_adr_i == `SAS_OFF_BND_HIGH) begin
            rdData = {22'h00_0000, bndHi_ff};
        end else if (wb_adr_i == `SAS_OFF_BND_LOW) begin
            rdData = {22'h00_0000, bndLo_ff};
        end else if (wb_adr_i == `SAS_OFF_BND_CHAN) begin
            rdData = {24'h00_0000, bndChan_ff};
        end else if (wb_adr_i >= `SAS_OFF_RESULT_BASE && wb_adr_i < `SAS_OFF_RESULT_END) begin
            rdData = resOff[2] ? {24'h00_0000, res_ff[resOff[5:3]][9:2]}
                               : {30'h0000_0000, res_ff[resOff[5:3]][1:0]};
        end
    end

    // ======================================================================
    // start sources; triggers only count in idle, so repeats are dropped
    // the start bit acts a clock late so it sees the enable and mode written with it
    wire pinEdge  = falling ? (pinPrev_ff & ~edgeTriggerPin) : (~pinPrev_ff & edgeTriggerPin);
    wire trig     = (src == SAS_SRC_TIMER) ? timerOvf
                  : (src == SAS_SRC_EDGE)  ? pinEdge
                  : startPend_ff;
    wire scanMode = mode == SAS_SCAN_SINGLE || mode == SAS_SCAN_CONT || mode == SAS_STEP;
    wire slotMode = mode == SAS_FIX_CONT || mode == SAS_SCAN_CONT || mode == SAS_DUAL_CONT;
    wire startOk  = state_ff == SAS_IDLE && enable && !powerDown && trig
                  && !(scanMode && scanMask == 8'h00);
    wire [3:0] scanNext = nextChan(scanMask, chan_ff);
    wire [3:0] scanFirst = nextChan(scanMask, 3'd7);

    // divider: tick every divRatio+1 clocks, frozen in power-down
    wire tick = enable && !powerDown && divCnt_ff == divRatio;

    // SAR step: keep the trial bit when the input is at or above the DAC
    wire [9:0] decided = cmpHigh ? dac_ff : code_ff;
    wire       stepNow = state_ff == SAS_CONVERT && tick;
    wire       convDone = stepNow && bitIdx_ff == 4'd0;
    wire [2:0] resIdx  = slotMode ? slot_ff : chan_ff;
    wire       scanLast = scanNext[3];

    // ======================================================================
    // boundary compare; outside criteria check early at four and at eight bits
    wire bndOut4  = bitIdx_ff == `SAS_EARLY_BIT
                  && isOutside(decided, bndHi_ff, bndLo_ff, `SAS_MASK_EARLY);
    wire bndOut8  = bitIdx_ff == `SAS_MID_BIT
                  && isOutside(decided, bndHi_ff, bndLo_ff, `SAS_MASK_MID);
    wire bndIn    = bitIdx_ff == 4'd0
                  && !isOutside(decided, bndHi_ff, bndLo_ff, `SAS_MASK_FULL);
    wire bndEvent = stepNow && bndEn && (outside ? (bndOut4 | bndOut8) : bndIn);

    // ======================================================================
    // completion events per mode
    logic irqHit;
    always_comb begin
        case (mode)
            SAS_FIX_CONT, SAS_DUAL_CONT: irqHit = by4 ? slot_ff[1:0] == 2'd3
                                                      : slot_ff == 3'd7;
            SAS_SCAN_SINGLE, SAS_SCAN_CONT: irqHit = scanLast
                                                   || (by4 && scanCnt_ff == 4'd3);
            default: irqHit = 1'b1;
        endcase
    end

    // ======================================================================
    // sequencer next state
    always_comb begin
        nxtState   = state_ff;
        nxtChan    = chan_ff;
        nxtBit     = bitIdx_ff;
        nxtCode    = code_ff;
        nxtDac     = dac_ff;
        nxtSlot    = slot_ff;
        nxtScanCnt = scanCnt_ff;
        nxtDualB   = dualB_ff;
        case (state_ff)
            SAS_IDLE: if (startOk) begin
                nxtState   = SAS_SAMPLE;
                nxtSlot    = 3'd0;
                nxtScanCnt = 4'd0;
                nxtDualB   = 1'b0;
                case (mode)
                    SAS_FIX_SINGLE, SAS_FIX_CONT: nxtChan = fixChan;
                    SAS_DUAL_CONT: nxtChan = fixChan;
                    SAS_STEP:      nxtChan = scanNext[2:0];
                    default:       nxtChan = scanFirst[2:0];
                endcase
            end
            SAS_SAMPLE: if (tick) begin
                nxtState = SAS_CONVERT;
                nxtBit   = `SAS_MSB_BIT;
                nxtCode  = 10'h000;
                nxtDac   = 10'h200;
            end
            SAS_CONVERT: if (tick) begin
                nxtCode = decided;
                if (bitIdx_ff != 4'd0) begin
                    nxtBit = bitIdx_ff - 4'd1;
                    nxtDac = decided | (10'h001 << nxtBit);
                end else begin
                    nxtSlot    = slot_ff + 3'd1;
                    nxtScanCnt = scanLast ? 4'd0 : scanCnt_ff + 4'd1;
                    case (mode)
                        SAS_FIX_CONT: nxtState = SAS_SAMPLE;
                        SAS_DUAL_CONT: begin
                            nxtState = SAS_SAMPLE;
                            nxtDualB = ~dualB_ff;
                            nxtChan  = dualB_ff ? fixChan : dualChan;
                        end
                        SAS_SCAN_CONT: begin
                            nxtState = SAS_SAMPLE;
                            nxtChan  = scanNext[2:0];
                        end
                        SAS_SCAN_SINGLE: begin
                            nxtState = scanLast ? SAS_IDLE : SAS_SAMPLE;
                            nxtChan  = scanLast ? chan_ff : scanNext[2:0];
                        end
                        default: nxtState = SAS_IDLE;
                    endcase
                end
            end
            default: nxtState = SAS_IDLE;
        endcase
        if (abort) begin
            nxtState = SAS_IDLE;
        end
    end

    // ======================================================================
    // sequencer registers; in power-down only an abort, pinPrev_ff and startPend_ff move without a tick
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff   <= SAS_IDLE;
            chan_ff    <= 3'd7;
            bitIdx_ff  <= 4'd0;
            code_ff    <= 10'h000;
            dac_ff     <= 10'h000;
            slot_ff    <= 3'd0;
            scanCnt_ff <= 4'd0;
            dualB_ff   <= 1'b0;
            divCnt_ff  <= 3'd0;
            pinPrev_ff <= 1'b0;
            startPend_ff <= 1'b0;
        end else begin
            state_ff   <= nxtState;
            chan_ff    <= nxtChan;
            bitIdx_ff  <= nxtBit;
            code_ff    <= nxtCode;
            dac_ff     <= nxtDac;
            slot_ff    <= nxtSlot;
            scanCnt_ff <= nxtScanCnt;
            dualB_ff   <= nxtDualB;
            divCnt_ff  <= (tick || !enable) ? 3'd0 : divCnt_ff + {2'b00, !powerDown};
            pinPrev_ff <= edgeTriggerPin;
            startPend_ff <= startWr;
        end
    end

    // result pairs are data only, no reset needed
    always_ff @(posedge clk) begin
        if (convDone) begin
            res_ff[resIdx] <= decided;
        end
    end

    // ======================================================================
    // software registers; hardware set wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff     <= `SAS_CTRL_RST;
            chSel_ff    <= `SAS_CHSEL_RST;
            bndHi_ff    <= `SAS_BND_HIGH_RST;
            bndLo_ff    <= `SAS_BND_LOW_RST;
            doneFlag_ff <= 1'b0;
            bndFlag_ff  <= 1'b0;
            bndChan_ff  <= 8'h00;
        end else begin
            if (wrCtrl) ctrl_ff <= ctrlNew[13:0];
            if (wbWr && wb_adr_i == `SAS_OFF_CHSEL)
                chSel_ff <= chSelNew[14:0];
            if (wbWr && wb_adr_i == `SAS_OFF_BND_HIGH)
                bndHi_ff <= bndHiNew[9:0];
            if (wbWr && wb_adr_i == `SAS_OFF_BND_LOW)
                bndLo_ff <= bndLoNew[9:0];
            doneFlag_ff <= (convDone && irqHit)
                         | (doneFlag_ff & ~(wrStat & statNew[`SAS_STAT_DONE]));
            bndFlag_ff  <= bndEvent | (bndFlag_ff & ~(wrStat & statNew[`SAS_STAT_BND]));
            bndChan_ff  <= ({8{bndEvent}} & (8'h01 << chan_ff))
                         | (bndChan_ff & ~({8{wrChan}} & statNew[7:0]));
        end
    end

    // ======================================================================
    // outputs, all registered
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_ff      <= 1'b0;
            rdData_ff   <= 32'h0000_0000;
            sample_ff   <= 1'b0;
            analogOn_ff <= 1'b0;
            intReq_ff   <= 1'b0;
        end else begin
            ack_ff      <= wbReq & ~ack_ff;
            rdData_ff   <= rdData;
            sample_ff   <= nxtState == SAS_SAMPLE;
            analogOn_ff <= enable & ~powerDown;
            // idle mode does not touch this request, so it can wake the core
            intReq_ff   <= (irqEn & ((convDone & irqHit) | doneFlag_ff))
                         | (bndEvent | bndFlag_ff);
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdData_ff;
    assign chanSel  = chan_ff;
    assign sampleEn = sample_ff;
    assign dacCode  = dac_ff;
    assign analogOn = analogOn_ff;
    assign intReq   = intReq_ff;

    // ======================================================================
    // assertions
    property p_single_halts;
        @(posedge clk) disable iff (rst)
        convDone && mode == SAS_FIX_SINGLE |=> state_ff == SAS_IDLE;
    endproperty
    a_single_halts: assert property (p_single_halts) else $error("single did not halt");

    property p_slot_steps;
        @(posedge clk) disable iff (rst)
        convDone && slotMode && !abort |=> slot_ff == $past(slot_ff) + 3'd1;
    endproperty
    a_slot_steps: assert property (p_slot_steps) else $error("slot did not step");

    property p_four_irq;
        @(posedge clk) disable iff (rst)
        convDone && mode == SAS_FIX_CONT && by4 && slot_ff[1:0] == 2'd3 |=> doneFlag_ff;
    endproperty
    a_four_irq: assert property (p_four_irq) else $error("no flag after four");

    property p_cont_runs;
        @(posedge clk) disable iff (rst)
        convDone && mode == SAS_FIX_CONT && !abort |=> state_ff == SAS_SAMPLE;
    endproperty
    a_cont_runs: assert property (p_cont_runs) else $error("continuous stopped");

    property p_dual_alt;
        @(posedge clk) disable iff (rst)
        convDone && mode == SAS_DUAL_CONT && !abort && !dualB_ff |=> chan_ff == dualChan;
    endproperty
    a_dual_alt: assert property (p_dual_alt) else $error("dual did not alternate");

    property p_busy_ignores;
        @(posedge clk) disable iff (rst)
        state_ff == SAS_CONVERT && bitIdx_ff != 4'd0 && !abort |=> state_ff == SAS_CONVERT;
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("conversion cut");

    property p_bnd_off;
        @(posedge clk) disable iff (rst)
        !bndEn |=> !$rose(bndFlag_ff);
    endproperty
    a_bnd_off: assert property (p_bnd_off) else $error("boundary while disabled");

    property p_irq_flag;
        @(posedge clk) disable iff (rst)
        doneFlag_ff && $past(irqEn) |-> intReq;
    endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("request missing");

    property p_pd_freeze;
        @(posedge clk) disable iff (rst)
        powerDown && enable && $past(powerDown) |-> $stable(code_ff) && $stable(divCnt_ff);
    endproperty
    a_pd_freeze: assert property (p_pd_freeze) else $error("runs in power-down");
endmodule

// *** sim/sas_analog_model.sv ***
/* analog side model: eight fixed channel levels feeding the comparator.
   assumes cmpHigh is only sampled by the sequencer while analogOn is high. */
`timescale 1ns/1ns
module sas_analog_model (
    // converter side
    input  wire logic       clk,
    input  wire logic [2:0] chanSel,
    input  wire logic [9:0] dacCode,
    input  wire logic       analogOn,
    // comparator answer
    output logic            cmpHigh
);
    // ======================================================================
    // unpowered comparator output wanders, so never hand out a stale level
    logic wander = 1'b0;
    always @(posedge clk) wander <= ~wander;
    // level of channel n is {n, 7'h55}, distinct for every channel
    assign cmpHigh = analogOn ? ({chanSel, 7'h55} >= dacCode) : wander;
endmodule

// *** sim/sas_sequencer_tb.sv ***
/* bench for the converter sequencer: register access, modes, starts, limits.
   assumes the analog model levels {ch, 7'h55} and a one-cycle bus answer. */
`timescale 1ns/1ns
`include "sas_defs.svh"
module sas_sequencer_tb;
    // ======================================================================
    // stimulus and observed signals
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, tOvf = 1'b0;
    logic pin = 1'b0, pd = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat, datO;
    logic ack, cmpHigh, sampleEn, analogOn, intReq;
    logic [2:0] chanSel;
    logic [9:0] dacCode;
    int error_cnt = 0, cmp_count = 0, cycCnt = 0;
    always #2 clk = ~clk;
    sas_sequencer dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack),
        .timerOvf(tOvf), .edgeTriggerPin(pin), .powerDown(pd), .cmpHigh(cmpHigh),
        .chanSel(chanSel), .sampleEn(sampleEn), .dacCode(dacCode), .analogOn(analogOn),
        .intReq(intReq));
    sas_analog_model model (.clk(clk), .chanSel(chanSel), .dacCode(dacCode),
        .analogOn(analogOn), .cmpHigh(cmpHigh));
    // ======================================================================
    // shared tasks: bus cycle, compare, one conversion run, result pair read
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do begin @(posedge clk); end while (ack !== 1'b1);
        rdat = datO;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %0t mismatch got %h expected %h", $time, s, e);
        end
    endtask
    // poll done; a hang ends in the cycle ceiling; pulse timer and pin together
    task conv(input logic [31:0] ctl, input logic [31:0] chs, input logic tmr);
        wb(1'b1, `SAS_OFF_CHSEL, chs);
        wb(1'b1, `SAS_OFF_STATUS, 32'h0000_0003);
        wb(1'b1, `SAS_OFF_BND_CHAN, 32'h0000_00FF);
        wb(1'b1, `SAS_OFF_CTRL, ctl);
        if (tmr) begin
            tOvf <= 1'b1; pin <= 1'b1;
            @(posedge clk);
            tOvf <= 1'b0; pin <= 1'b0;
        end
        do begin wb(1'b0, `SAS_OFF_STATUS, 32'h0000_0000); end
        while (rdat[0] !== 1'b1);
    endtask
    task pair(input logic [2:0] p, input logic [2:0] ch);
        wb(1'b0, `SAS_OFF_RESULT_BASE + {2'h0, p, 3'h0}, 32'h0000_0000);
        chk(rdat, {30'h0, 2'h1});
        wb(1'b0, `SAS_OFF_RESULT_BASE + {2'h0, p, 3'h4}, 32'h0000_0000);
        chk(rdat, {24'h0, ch, 5'h15});
    endtask
    // ======================================================================
    // scenarios
    task fixSingle; // fixed channel five, immediate start, boundary off
        conv(32'h0000_4111, 32'h0000_0500, 1'b0);
        pair(3'd5, 3'd5);
        wb(1'b0, `SAS_OFF_STATUS, 32'h0000_0000);
        chk(rdat, 32'h0000_0001);
        chk({31'h0, intReq}, 32'h0000_0001);
    endtask
    task scanSingle; // two channels far apart land in their own pairs
        conv(32'h0000_4115, 32'h0000_0081, 1'b0);
        pair(3'd0, 3'd0);
        pair(3'd7, 3'd7);
    endtask
    task timerStart; // timer source: nothing until the overflow pulse
        conv(32'h0000_0101, 32'h0000_0300, 1'b1);
        pair(3'd3, 3'd3);
    endtask
    task contRun; // fixed channel six continuous, flag after four, then stop
        conv(32'h0000_4193, 32'h0000_0600, 1'b0);
        wb(1'b0, `SAS_OFF_STATUS, 32'h0000_0000);
        chk({31'h0, rdat[2]}, 32'h0000_0001);
        wb(1'b1, `SAS_OFF_CTRL, 32'h0000_8000);
        pair(3'd0, 3'd6);
        pair(3'd3, 3'd6);
    endtask
    task edgeStart; // falling pin edge starts channel two; timer pulse ignored
        conv(32'h0000_0161, 32'h0000_0200, 1'b1);
        pair(3'd2, 3'd2);
    endtask
    task powerOff; // power-down: start refused, analog side unpowered
        pd <= 1'b1;
        wb(1'b1, `SAS_OFF_STATUS, 32'h0000_0003);
        wb(1'b1, `SAS_OFF_CTRL, 32'h0000_4111);
        repeat (40) @(posedge clk);
        wb(1'b0, `SAS_OFF_STATUS, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        chk({31'h0, analogOn}, 32'h0000_0000);
        pd <= 1'b0;
    endtask
    task boundary; // level 0x2D5 lies above a high limit of 0x100
        wb(1'b1, `SAS_OFF_BND_HIGH, 32'h0000_0100);
        conv(32'h0000_4711, 32'h0000_0500, 1'b0);
        wb(1'b0, `SAS_OFF_STATUS, 32'h0000_0000);
        chk(rdat, 32'h0000_0003);
        wb(1'b0, `SAS_OFF_BND_CHAN, 32'h0000_0000);
        chk(rdat, 32'h0000_0020);
    endtask
    // ======================================================================
    // verdict, run order and hang guard
    task complete_run;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycCnt++;
        if (cycCnt == 20000) begin error_cnt++; complete_run(); end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        fixSingle(); scanSingle(); timerStart(); contRun(); edgeStart(); boundary(); powerOff();
        complete_run();
    end
endmodule
